//--- rtl/sfr_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/10ps
module sfr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic flush,
    // Fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Drain side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W-1:0] rdPtr_reg;
    logic [CNT_W-1:0] count_reg;
    logic push;
    logic pop;

    assign inReady = (count_reg != CNT_W'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem_reg[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= (wrPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_reg + PTR_W'(1);
            end
            if (pop) begin
                rdPtr_reg <= (rdPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_reg + PTR_W'(1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + CNT_W'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - CNT_W'(1);
            end
        end
    end
endmodule : sfr_fifo

//--- rtl/sfr_pkg.sv
// Shared constants and types of the serial flash read path
package sfr_pkg;

    // ------------------------------------------------------------------
    // Read opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_NORMAL_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
    localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4b;
    localparam logic [7:0] OP_INFO_ROW_READ = 8'h68;

    // ------------------------------------------------------------------
    // Field widths
    // ------------------------------------------------------------------
    localparam int CMD_BITS = 8;
    localparam int ADDR_BITS = 24;
    localparam int DEC_ADDR_BITS = 21;
    localparam int DATA_BITS = 8;
    localparam int IO_LINES = 4;

    // ------------------------------------------------------------------
    // Dummy and mode timing, in serial clocks
    // ------------------------------------------------------------------
    localparam logic [3:0] DUMMY_FAST_DEFAULT = 4'h8;
    localparam logic [3:0] DUMMY_QPI_DEFAULT = 4'h6;
    localparam logic [3:0] DUMMY_DUAL_DEFAULT = 4'h4;
    localparam logic [3:0] MODE_CLOCKS_DUAL = 4'h4;
    localparam logic [3:0] SKIP_NIBBLE = 4'ha;

    // Host-side serial clock limits, in MHz
    localparam int NORMAL_READ_MAX_MHZ = 50;
    localparam int FAST_READ_MAX_MHZ = 133;

    // ------------------------------------------------------------------
    // Buffer shape and pin synchroniser reset, {csN, sck, io[3:0]}
    // ------------------------------------------------------------------
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [5:0] PIN_RESET = 6'h20;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [2:0] sfr_lanes_t;
    localparam sfr_lanes_t LANES_1 = 3'h1;
    localparam sfr_lanes_t LANES_2 = 3'h2;
    localparam sfr_lanes_t LANES_4 = 3'h4;

    typedef struct packed {
        logic dtrMode;
        logic quadEnable;
        logic resetPinSel;
        logic fourLineMode;
        logic writeInProgress;
        logic [3:0] fastDummy;
        logic [3:0] qpiDummy;
        logic [3:0] dualDummy;
    } sfr_cfg_t;

    typedef struct packed {
        logic valid;
        sfr_lanes_t addrLanes;
        logic [3:0] dummy;
        sfr_lanes_t dataLanes;
        logic modeBits;
    } sfr_phase_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } sfr_state_t;

endpackage : sfr_pkg

//--- rtl/sfr_read_path.sv
// Serial flash read front end: command, address, dummy, data and pause
`timescale 1ns/10ps

// Contract
// R1: Normal read only up to 50MHz
// R2: 24 address bits, only A20-A0 used
// R3: Single-line data MSB first, address increments
// R4: Address wraps to zero past top
// R5: Chip select high aborts, outputs released
// R6: Reads ignored while write in progress
// R7: Fast read: opcode, address, configurable dummy
// R8: Sample on rising, launch on falling
// R9: Four-line mode: 2 cmd, 6 addr clocks
// R10: Quad, unique-ID, info-row reads share sequence
// R11: Pause and resume while clock low
// R12: Paused: outputs floated, inputs ignored
// R13: No pause in DTR, quad or reset-pin
// R14: Dual read address two bits, MSB IO1
// R15: Dual data pairs, MSB on IO1
// R16: Four clocks after address carry mode byte
// R17: Upper nibble 1010 enters command skip
// R18: Other nibble leaves skip, mode kept
// R19: Dummy count includes mode clocks
// R20: Host floats mode nibble, avoids contention
// R21: Host holds select low whole read
// R22: IO lines driven only in data phase
module sfr_read_path (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Serial pins
    input wire logic csN,
    input wire logic sckIn,
    input wire logic [3:0] ioIn,
    output logic [3:0] ioOut,
    output logic [3:0] ioOeN,
    // Configuration and status
    input wire sfr_pkg::sfr_cfg_t cfg,
    output logic skipModeActive,
    // Memory array
    output logic memReq,
    output logic [20:0] memAddr,
    input wire logic [7:0] memData,
    input wire logic memAck
);
    import sfr_pkg::*;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [23:0] shiftInBits(input logic [23:0] r, input logic [3:0] io,
                                                input sfr_lanes_t lanes);
        logic [23:0] res;
        res = {r[22:0], io[0]};
        unique case (lanes)
            LANES_2: res = {r[21:0], io[1], io[0]}; // R14
            LANES_4: res = {r[19:0], io[3:0]};
            default: res = {r[22:0], io[0]};
        endcase
        return res;
    endfunction : shiftInBits

    function automatic logic [4:0] phaseClocks(input logic [4:0] bits, input sfr_lanes_t lanes);
        logic [4:0] res;
        res = bits;
        unique case (lanes)
            LANES_2: res = bits >> 1;
            LANES_4: res = bits >> 2; // R9
            default: res = bits;
        endcase
        return res;
    endfunction : phaseClocks

    function automatic logic [3:0] laneMask(input sfr_lanes_t lanes);
        logic [3:0] res;
        res = 4'h0;
        unique case (lanes)
            LANES_1: res = 4'h2;
            LANES_2: res = 4'h3;
            LANES_4: res = 4'hf;
            default: res = 4'h0;
        endcase
        return res;
    endfunction : laneMask

    function automatic logic [3:0] outBits(input logic [7:0] b, input sfr_lanes_t lanes);
        logic [3:0] res;
        res = 4'h0;
        unique case (lanes)
            LANES_1: res = {2'b00, b[7], 1'b0}; // R3
            LANES_2: res = {2'b00, b[7], b[6]}; // R15
            LANES_4: res = b[7:4];
            default: res = 4'h0;
        endcase
        return res;
    endfunction : outBits

    function automatic sfr_phase_t decodeOp(input logic [7:0] op, input sfr_cfg_t c);
        sfr_phase_t ph;
        ph = '0;
        if (c.fourLineMode) begin
            if (op == OP_FAST_READ || op == OP_QUAD_IO_READ ||
                op == OP_UNIQUE_ID_READ || op == OP_INFO_ROW_READ) begin // R10
                ph.valid = 1'b1;
                ph.addrLanes = LANES_4; // R9
                ph.dummy = c.qpiDummy;
                ph.dataLanes = LANES_4;
            end
        end else if (op == OP_NORMAL_READ) begin
            // Host keeps the serial clock within the normal read limit
            ph.valid = 1'b1; // R1
            ph.addrLanes = LANES_1;
            ph.dummy = 4'h0;
            ph.dataLanes = LANES_1;
        end else if (op == OP_FAST_READ) begin
            ph.valid = 1'b1; // R7
            ph.addrLanes = LANES_1;
            ph.dummy = c.fastDummy;
            ph.dataLanes = LANES_1;
        end else if (op == OP_DUAL_IO_READ) begin
            ph.valid = 1'b1;
            ph.addrLanes = LANES_2; // R14
            ph.dummy = (c.dualDummy < MODE_CLOCKS_DUAL) ? MODE_CLOCKS_DUAL : c.dualDummy; // R19
            ph.dataLanes = LANES_2;
            ph.modeBits = 1'b1;
        end
        return ph;
    endfunction : decodeOp

    // ------------------------------------------------------------------
    // Pin synchronisation and serial clock edges
    // ------------------------------------------------------------------
    logic [5:0] pinSync;
    logic csActive;
    logic sckS;
    logic sckD_reg;
    logic [3:0] ioS;
    logic holdS;
    logic paused_reg;
    logic sckRise;
    logic sckFall;

    sfr_sync #(
        .WIDTH(6),
        .RESET_VAL(PIN_RESET)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .asyncIn({csN, sckIn, ioIn}),
        .syncOut(pinSync)
    );

    assign csActive = ~pinSync[5];
    assign sckS = pinSync[4];
    assign ioS = pinSync[3:0];
    assign holdS = pinSync[3];

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sckD_reg <= 1'b0;
        end else begin
            sckD_reg <= sckS;
        end
    end

    // Edges are dropped while paused or deselected
    assign sckRise = sckS && !sckD_reg && csActive && !paused_reg; // R8 R12
    assign sckFall = !sckS && sckD_reg && csActive && !paused_reg; // R8

    // ------------------------------------------------------------------
    // Pause control on the shared IO3 pin
    // ------------------------------------------------------------------
    logic holdAllowed;

    assign holdAllowed = !cfg.dtrMode && !cfg.quadEnable && !cfg.resetPinSel &&
                         !cfg.fourLineMode; // R13

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            paused_reg <= 1'b0;
        end else if (!csActive || !holdAllowed) begin
            paused_reg <= 1'b0;
        end else if (!sckS) begin
            paused_reg <= !holdS; // R11
        end
    end

    // ------------------------------------------------------------------
    // Sequence state machine
    // ------------------------------------------------------------------
    sfr_state_t state_reg;
    logic [4:0] cnt_reg;
    logic [23:0] shift_reg;
    logic [23:0] shiftNext;
    sfr_phase_t phase_reg;
    sfr_phase_t phaseNext;
    sfr_lanes_t lanes_reg;
    logic [7:0] modeByte_reg;
    logic [7:0] modeNext;
    logic skip_reg;
    logic lastClock;
    logic addrDone;

    assign shiftNext = shiftInBits(shift_reg, ioS, lanes_reg);
    assign phaseNext = decodeOp(shiftNext[7:0], cfg);
    assign modeNext = {modeByte_reg[5:0], ioS[1:0]};
    assign lastClock = (state_reg == ST_CMD) ?
        (cnt_reg == phaseClocks(5'(CMD_BITS), lanes_reg) - 5'h01) :
        (cnt_reg == phaseClocks(5'(ADDR_BITS), lanes_reg) - 5'h01);
    assign addrDone = sckRise && (state_reg == ST_ADDR) && lastClock;
    assign skipModeActive = skip_reg;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 5'h00;
            shift_reg <= 24'h000000;
            phase_reg <= '0;
            lanes_reg <= LANES_1;
            modeByte_reg <= 8'h00;
            skip_reg <= 1'b0;
        end else if (!csActive) begin
            state_reg <= ST_IDLE; // R5 R21
            cnt_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 5'h00;
                    shift_reg <= 24'h000000;
                    if (skip_reg) begin
                        // Skip mode: straight to a dual address
                        phase_reg <= decodeOp(OP_DUAL_IO_READ, cfg); // R17
                        lanes_reg <= LANES_2;
                        state_reg <= cfg.writeInProgress ? ST_IGNORE : ST_ADDR; // R6
                    end else begin
                        lanes_reg <= cfg.fourLineMode ? LANES_4 : LANES_1; // R9 R18
                        state_reg <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (sckRise) begin
                        shift_reg <= shiftNext;
                        cnt_reg <= cnt_reg + 5'h01;
                        if (lastClock) begin
                            cnt_reg <= 5'h00;
                            shift_reg <= 24'h000000;
                            phase_reg <= phaseNext;
                            lanes_reg <= phaseNext.addrLanes;
                            if (phaseNext.valid && !cfg.writeInProgress) begin // R6
                                state_reg <= ST_ADDR;
                            end else begin
                                state_reg <= ST_IGNORE;
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (sckRise) begin
                        shift_reg <= shiftNext; // R2
                        cnt_reg <= cnt_reg + 5'h01;
                        if (lastClock) begin
                            cnt_reg <= 5'h00;
                            modeByte_reg <= 8'h00;
                            state_reg <= (phase_reg.dummy == 4'h0) ? ST_DATA : ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (sckRise) begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (phase_reg.modeBits && cnt_reg < {1'b0, MODE_CLOCKS_DUAL}) begin
                            modeByte_reg <= modeNext; // R16
                            if (cnt_reg == {1'b0, MODE_CLOCKS_DUAL} - 5'h01) begin
                                skip_reg <= (modeNext[7:4] == SKIP_NIBBLE); // R17 R18 R20
                            end
                        end
                        if (cnt_reg + 5'h01 == {1'b0, phase_reg.dummy}) begin
                            state_reg <= ST_DATA; // R19
                        end
                    end
                end
                ST_DATA: begin
                    state_reg <= ST_DATA;
                end
                ST_IGNORE: begin
                    state_reg <= ST_IGNORE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Array prefetch into the byte buffer
    // ------------------------------------------------------------------
    logic fetchEn_reg;
    logic pending_reg;
    logic [20:0] fetchAddr_reg;
    logic issue;
    logic fifoInReady;
    logic fifoOutValid;
    logic [7:0] fifoOutData;
    logic fifoPop;

    assign issue = fetchEn_reg && !pending_reg && fifoInReady && csActive;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fetchEn_reg <= 1'b0;
            fetchAddr_reg <= 21'h000000;
        end else if (addrDone) begin
            fetchEn_reg <= 1'b1;
            fetchAddr_reg <= shiftNext[DEC_ADDR_BITS-1:0]; // R2
        end else if (!csActive) begin
            fetchEn_reg <= 1'b0; // R5
        end else if (issue) begin
            fetchAddr_reg <= fetchAddr_reg + 21'h000001; // R3 R4
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pending_reg <= 1'b0;
            memReq <= 1'b0;
            memAddr <= 21'h000000;
        end else begin
            memReq <= issue;
            if (issue) begin
                memAddr <= fetchAddr_reg;
                pending_reg <= 1'b1;
            end else if (memAck) begin
                pending_reg <= 1'b0;
            end
        end
    end

    sfr_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .flush(!csActive),
        .inValid(memAck && fetchEn_reg),
        .inData(memData),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData),
        .outReady(fifoPop)
    );

    // ------------------------------------------------------------------
    // Data launch on falling serial clock edges
    // ------------------------------------------------------------------
    logic [7:0] dataShift_reg;
    logic [3:0] bitsLeft_reg;
    logic started_reg;
    logic [7:0] loadByte;
    logic dataFall;

    assign dataFall = sckFall && (state_reg == ST_DATA);
    assign fifoPop = dataFall && (bitsLeft_reg == 4'h0) && fifoOutValid;
    assign loadByte = fifoOutValid ? fifoOutData : 8'h00;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ioOut <= 4'h0;
            ioOeN <= 4'hf;
            dataShift_reg <= 8'h00;
            bitsLeft_reg <= 4'h0;
            started_reg <= 1'b0;
        end else if (!csActive || state_reg != ST_DATA) begin
            ioOut <= 4'h0; // R5 R22
            ioOeN <= 4'hf;
            bitsLeft_reg <= 4'h0;
            started_reg <= 1'b0;
        end else begin
            if (dataFall) begin
                started_reg <= 1'b1;
                if (bitsLeft_reg == 4'h0) begin
                    ioOut <= outBits(loadByte, phase_reg.dataLanes); // R3
                    dataShift_reg <= loadByte << phase_reg.dataLanes;
                    bitsLeft_reg <= 4'(DATA_BITS) - {1'b0, phase_reg.dataLanes};
                end else begin
                    ioOut <= outBits(dataShift_reg, phase_reg.dataLanes); // R15
                    dataShift_reg <= dataShift_reg << phase_reg.dataLanes;
                    bitsLeft_reg <= bitsLeft_reg - {1'b0, phase_reg.dataLanes};
                end
            end
            // Float while paused, drive only once data has launched
            ioOeN <= (paused_reg || !(started_reg || dataFall)) ? 4'hf :
                     ~laneMask(phase_reg.dataLanes); // R12 R22
        end
    end
endmodule : sfr_read_path

//--- rtl/sfr_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module sfr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end
endmodule : sfr_sync

//--- sim/sfr_mem_model.sv
// Memory array stand-in answering byte fetches after a short random wait
`timescale 1ns/10ps
module sfr_mem_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Fetch port
    input wire logic memReq,
    input wire logic [20:0] memAddr,
    output logic [7:0] memData,
    output logic memAck
);
    logic [1:0] cnt;
    // Data churns outside the ack so a stale byte never looks valid
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            memAck <= 1'b0;
            cnt <= 2'h0;
            memData <= 8'h00;
        end else begin
            memAck <= cnt == 2'h1;
            memData <= cnt == 2'h1 ? memAddr[7:0] ^ memAddr[20:13] : ~memData;
            if (memReq) begin
                cnt <= 2'(1 + ($urandom & 1));
            end else if (cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end
        end
    end
endmodule : sfr_mem_model

//--- sim/sfr_read_path_sva.sv
// Port checks of the read path
`timescale 1ns/10ps
module sfr_read_path_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Pins, config, status, memory
    input wire logic csN,
    input wire logic sckIn,
    input wire logic [3:0] ioIn,
    input wire logic [3:0] ioOut,
    input wire logic [3:0] ioOeN,
    input wire sfr_pkg::sfr_cfg_t cfg,
    input wire logic skipModeActive,
    input wire logic memReq,
    input wire logic [20:0] memAddr
);
    import sfr_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic pauseOk;
    assign pauseOk = !(cfg.dtrMode || cfg.quadEnable || cfg.resetPinSel || cfg.fourLineMode);
    sequence s_desel;
        csN [*4];
    endsequence
    sequence s_held;
        (!csN && !sckIn && !ioIn[3] && pauseOk) [*7];
    endsequence
    a_oe_desel: assert property (s_desel |=> ioOeN == 4'hf)
        else $error("pins driven while deselected");
    a_out_desel: assert property (s_desel |=> ioOut == 4'h0)
        else $error("output not cleared while deselected");
    a_oe_shape: assert property (ioOeN inside {4'hf, 4'hd, 4'hc, 4'h0})
        else $error("illegal enable pattern");
    a_four_lane: assert property (ioOeN != 4'hf |-> (ioOeN == 4'h0) == cfg.fourLineMode)
        else $error("lane count disagrees with mode");
    a_pause_float: assert property (s_held |-> ioOeN == 4'hf)
        else $error("pins driven while paused");
    a_req_pulse: assert property (memReq |=> !memReq [*2])
        else $error("fetch requests too close");
    a_addr_stable: assert property (!memReq |-> $stable(memAddr))
        else $error("fetch address moved without request");
    a_skip_keep: assert property (s_desel |=> $stable(skipModeActive))
        else $error("skip mode changed while deselected");
endmodule : sfr_read_path_sva
bind sfr_read_path sfr_read_path_sva i_sfr_read_path_sva (.ref_clk(ref_clk), .resetn(resetn),
    .csN(csN), .sckIn(sckIn), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN), .cfg(cfg),
    .skipModeActive(skipModeActive), .memReq(memReq), .memAddr(memAddr));

//--- sim/tb_top.sv
// Self-checking bench of the read path acting as serial host
`timescale 1ns/10ps
module tb_top;
    import sfr_pkg::*;
    logic ref_clk = 0;
    logic resetn = 0, csN = 1, sckIn = 0;
    logic [3:0] hostIo = 4'hf;
    logic [3:0] ioOut, ioOeN, ioIn;
    sfr_cfg_t cfg;
    logic skipModeActive, memReq, memAck;
    logic [20:0] memAddr;
    logic [7:0] memData;
    int err_count = 0, total_checks = 0;
    int a;
    always #10 ref_clk = ~ref_clk;
    // Wire level: device drive wins where enabled
    assign ioIn = (hostIo & ioOeN) | (ioOut & ~ioOeN);
    sfr_read_path i_sfr_read_path (.ref_clk(ref_clk), .resetn(resetn), .csN(csN),
        .sckIn(sckIn), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN), .cfg(cfg),
        .skipModeActive(skipModeActive), .memReq(memReq), .memAddr(memAddr),
        .memData(memData), .memAck(memAck));
    sfr_mem_model i_sfr_mem_model (.ref_clk(ref_clk), .resetn(resetn), .memReq(memReq),
        .memAddr(memAddr), .memData(memData), .memAck(memAck));
    // ------------------------------------------------------------------
    // Host tasks
    // ------------------------------------------------------------------
    function automatic logic [7:0] ex(int x);
        return 8'((x ^ (x >> 13)) & 255);
    endfunction : ex
    task automatic half;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : half
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic send(int v, int n, int w);
        for (int i = n - 1; i >= 0; i--) begin
            sckIn = 0;
            hostIo = w == 4 ? v[4*i+:4] : w == 2 ? {2'h3, v[2*i+:2]} : {3'h7, v[i]};
            half;
            sckIn = 1;
            half;
        end
    endtask : send
    task automatic recv(int x, int w, int n, bit p);
        logic [7:0] b;
        logic [3:0] oe;
        bit np;
        b = 8'h00;
        np = cfg.dtrMode | cfg.quadEnable | cfg.resetPinSel;
        oe = w == 1 ? 4'hd : w == 2 ? 4'hc : 4'h0;
        x &= 'h1fffff;
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8 / w; i++) begin
                sckIn = 0;
                half;
                if (p && k == 1 && i == 0) begin
                    hostIo[3] = 0;
                    half;
                    if (!np) begin
                        sckIn = 1;
                        half;
                        sckIn = 0;
                        half;
                    end
                    chk({4'h0, ioOeN}, np ? 8'h0d : 8'h0f);
                    hostIo[3] = 1;
                    half;
                end
                if (i == 0) chk({4'h0, ioOeN}, {4'h0, oe});
                b = w == 1 ? {b[6:0], ioOut[1]} : w == 2 ? {b[5:0], ioOut[1:0]} : {b[3:0], ioOut};
                sckIn = 1;
                half;
            end
            chk(b, ex(x));
            x = (x + 1) & 'h1fffff;
        end
    endtask : recv
    task automatic rd(int op, int x, int wc, int wa, int dm, int md, int wd, int n, bit p);
        csN = 0;
        half;
        if (op >= 0) send(op, 8 / wc, wc);
        send(x, 24 / wa, wa);
        if (md >= 0) send(md, 4, 2);
        send(-1, dm - (md >= 0 ? 4 : 0), wa);
        recv(x, wd, n, p);
    endtask : rd
    task automatic desel(string s);
        csN = 1;
        sckIn = 0;
        hostIo = 4'hf;
        repeat (6) @(posedge ref_clk);
        #1;
        chk({4'h0, ioOeN}, 8'h0f);
        $display("done %s", s);
    endtask : desel
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        cfg = '0;
        cfg.fastDummy = DUMMY_FAST_DEFAULT;
        cfg.qpiDummy = DUMMY_QPI_DEFAULT;
        cfg.dualDummy = DUMMY_DUAL_DEFAULT;
        void'($urandom(79755));
        repeat (10) @(posedge ref_clk);
        #1 resetn = 1;
        half;
        a = $urandom;
        rd(8'h03, {a[23:21], 21'h1ffffe}, 1, 1, 0, -1, 1, 3, 0);
        desel("normal wrap");
        for (int d = 5; d <= 8; d += 3) begin
            cfg.fastDummy = 4'(d);
            rd(8'h0b, $urandom, 1, 1, d, -1, 1, 2, 0);
            desel("fast");
        end
        a = $urandom;
        rd(8'hbb, a, 1, 2, 4, 8'haf, 2, 2, 0);
        chk({7'h0, skipModeActive}, 8'h01);
        desel("dual enter skip");
        rd(-1, a + 9, 2, 2, 4, 8'h3f, 2, 2, 0);
        chk({7'h0, skipModeActive}, 8'h00);
        desel("dual leave skip");
        cfg.fourLineMode = 1;
        for (int j = 0; j < 4; j++) begin
            rd(j == 0 ? 8'h0b : j == 1 ? 8'heb : j == 2 ? 8'h4b : 8'h68, $urandom,
                4, 4, 6, -1, 4, 2, 0);
            desel("four line");
        end
        cfg.fourLineMode = 0;
        cfg.writeInProgress = 1;
        rd(8'h03, $urandom, 1, 1, 0, -1, 1, 0, 0);
        send(-1, 8, 1);
        chk({4'h0, ioOeN}, 8'h0f);
        desel("busy");
        cfg.writeInProgress = 0;
        for (int q = 0; q < 4; q++) begin
            {cfg.dtrMode, cfg.quadEnable, cfg.resetPinSel} = 3'(8 >> q);
            rd(8'h03, $urandom, 1, 1, 0, -1, 1, 2, 1);
            desel("pause");
        end
        end_of_test;
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_count++;
        end_of_test;
    end
endmodule : tb_top
